// *** verif/dra_ctl_model.sv ***
// Controller-side partner model: link commands and write bursts
`timescale 1ns/10ps
`default_nettype none
module dra_ctl_model (
    input  wire logic              lclk_i,
    input  wire logic              dqs_oe_i,
    output var dra_pkg::dra_cmd_bus_t cmd_o,
    output logic [7:0]             dq_o,
    output logic                   dm_o,
    output logic                   dqs_o
);
    int   lc   = 0;
    logic cal  = 1'b0;
    logic par  = 1'b0;
    logic oe_q = 1'b0;
    initial begin
        cmd_o = '{2'h3, 3'h7, 3'h0, 15'h0};
        dq_o  = 8'h00;
        dm_o  = 1'b0;
        dqs_o = 1'b0;
    end
    // ----------------------------------------
    // Command phase learnt from the first read
    // ----------------------------------------
    always @(posedge lclk_i) begin
        lc <= lc + 1;
        oe_q <= dqs_oe_i;
        if (dqs_oe_i && !oe_q && !cal) begin
            par <= lc[0];
            cal <= 1'b1;
        end
    end
    // Unaligned commands are held two cycles so one phase-0 edge takes them
    task automatic issue(input dra_pkg::dra_cmd_bus_t c);
        @(negedge lclk_i);
        while (cal && lc[0] != par) @(negedge lclk_i);
        @(posedge lclk_i);
        cmd_o <= c;
        repeat (cal ? 1 : 2) @(posedge lclk_i);
        cmd_o <= '{2'h3, ~c.rcw, ~c.ba, ~c.addr};
    endtask : issue
    task automatic burst(input logic [63:0] d, input logic [7:0] m);
        int j;
        repeat (cal ? 9 : 8) @(posedge lclk_i);
        for (int k = 0; k < 9; k++) begin
            j = (k < 8) ? k : 7;
            dq_o <= d[8*j+:8];
            dm_o <= m[j];
            @(negedge lclk_i);
            dqs_o <= ~k[0];
            @(posedge lclk_i);
        end
        dq_o <= ~dq_o;
        dm_o <= 1'b0;
        dqs_o <= 1'b0;
    endtask : burst
endmodule : dra_ctl_model
`default_nettype wire

// *** verif/tb_dual_rank_ddr3_data_access.sv ***
// Self-checking bench for the dual-rank DDR3 data access block
`timescale 1ns/10ps
`default_nettype none
module tb_dual_rank_ddr3_data_access;
    logic                  mclk = 1'b0, lclk = 1'b0, rst = 1'b1, cfg_x8 = 1'b1;
    logic                  busy, dqs, dqs_n, dqs_oe, tdqs_oe, dm, dqs_m, tdq, tdq_n;
    logic [7:0]            dq, dq_oe, dq_m;
    wire logic [7:0]       dq_w = (dq_oe & dq) | (~dq_oe & dq_m);
    wire logic             dqs_w = dqs_oe ? dqs : dqs_m;
    dra_pkg::dra_cmd_bus_t cmd;
    int                    n_errors = 0, comparisons = 0, seed = 32'h8f96ce00;
    logic [16:0]           q[$];
    logic [16:0]           e;
    logic [7:0]            mem[int];
    logic [1:0]            row[2][8];
    bit                    opn[2][8];
    logic [1:0]            bl = 2'h0;
    bit                    ilv = 0, tdqs = 0, x8 = 1;
    always #20 mclk = ~mclk;
    always #7.5 lclk = ~lclk;
    dra_ddr3_dev #(.ROW_W(2), .COL_W(5)) dra_ddr3_dev_i (
        .mclk_i(mclk), .rst_i(rst), .ce_i(1'b1), .cfg_x8_i(cfg_x8), .busy_o(busy),
        .link_clk_i(lclk), .cmd_i(cmd), .dq_i(dq_w), .dq_o(dq), .dq_oe_o(dq_oe),
        .dqs_i(dqs_w), .dm_i(dm), .dqs_o(dqs), .dqs_n_o(dqs_n), .dqs_oe_o(dqs_oe),
        .tdqs_o(tdq), .tdqs_n_o(tdq_n), .tdqs_oe_o(tdqs_oe));
    dra_ctl_model dra_ctl_model_i (.lclk_i(lclk), .dqs_oe_i(dqs_oe), .cmd_o(cmd),
        .dq_o(dq_m), .dm_o(dm), .dqs_o(dqs_m));
    // ----------------------------
    // Tasks, read monitor, verdict
    // ----------------------------
    task automatic bad(input string n, input logic [31:0] x, input logic [31:0] s);
        n_errors++;
        $display("BAD %s expected %h seen %h", n, x, s);
    endtask : bad
    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic cmd_to(input int r, input logic [2:0] op, input logic [2:0] b,
                          input logic [14:0] a);
        dra_ctl_model_i.issue('{r > 1 ? 2'h3 : (r ? 2'h1 : 2'h2), op, b, a});
    endtask : cmd_to
    task automatic mr(input logic [2:0] b, input logic [14:0] a);
        cmd_to(0, dra_pkg::CMD_MRS, b, a);
        cmd_to(1, dra_pkg::CMD_MRS, b, a);
    endtask : mr
    task automatic mode(input logic [1:0] m, input bit i);
        bl = m;
        ilv = i;
        mr(dra_pkg::MR0_SEL, {11'h0, i, 1'b0, m});
    endtask : mode
    task automatic act(input int r, input logic [2:0] b);
        row[r][b] = 2'($random(seed));
        opn[r][b] = 1;
        cmd_to(r, dra_pkg::CMD_ACT, b, {13'h0, row[r][b]});
    endtask : act
    task automatic xfer(input bit w, input int r, input logic [2:0] b, input logic [4:0] c,
                        input bit a12, input bit ap, input logic [7:0] m, input bit ds);
        logic [63:0] d;
        logic [2:0]  ix;
        int          key;
        int          nb;
        d = {$random(seed), $random(seed)};
        if (!dra_ctl_model_i.cal) d = {8{d[7:0]}};
        nb = (bl == dra_pkg::BL_BC4 || (bl == dra_pkg::BL_OTF && !a12)) ? 4 : 8;
        for (int k = 0; k < nb && opn[r][b] && !ds; k++) begin
            ix = ilv ? c[2:0] ^ k[2:0] : c[2:0] + k[2:0];
            key = int'({r[0], b, row[r][b], c[4:3], ix});
            if (!w) q.push_back({~k[0], x8 ? dra_pkg::LANE_X8 : dra_pkg::LANE_X4, mem[key]});
            else if (!m[k] || (x8 && tdqs))
                mem[key] = x8 ? d[8*k+:8] : {mem[key][7:4], d[8*k+:4]};
        end
        cmd_to(ds ? 2 : r, w ? dra_pkg::CMD_WR : dra_pkg::CMD_RD, b,
               {2'h0, a12, 1'b0, ap, 5'h0, c});
        if (w) dra_ctl_model_i.burst(d, m);
        else repeat (14) @(posedge lclk);
        if (opn[r][b] && !ds) begin
            comparisons++;
            if (busy !== 1'b1) bad("busy", 32'h1, {31'h0, busy});
        end
        if (ap) opn[r][b] = 0;
        repeat (30) @(posedge lclk);
    endtask : xfer
    always @(posedge lclk) if (dqs_oe === 1'b1) begin
        comparisons++;
        e = (q.size() != 0) ? q.pop_front() : 17'h0;
        if ({dqs, dqs_n, dq_oe, dq & dq_oe, tdqs_oe, tdqs_oe & (tdq ^ dqs),
             tdqs_oe & (tdq_n ^ dqs_n)} !==
            {e[16], ~e[16], e[15:8], e[7:0] & e[15:8], x8 && tdqs, 2'h0})
            bad("read beat", {15'h0, e}, {15'h0, dqs, dq_oe, dq});
    end
    initial begin
        #300000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (12) @(posedge lclk);
        mode(dra_pkg::BL_OTF, 0);
        mr(dra_pkg::MR1_SEL, 15'h0);
        act(0, 3'h3);
        act(1, 3'h5);
        xfer(1, 0, 3'h3, 5'h00, 1, 0, 8'h00, 0);
        xfer(0, 0, 3'h3, 5'h00, 1, 0, 8'h00, 0);
        xfer(1, 0, 3'h3, 5'h0d, 1, 0, 8'h00, 0);
        xfer(1, 1, 3'h5, 5'h0d, 1, 0, 8'h00, 0);
        xfer(0, 0, 3'h3, 5'h0d, 1, 0, 8'h00, 0);
        xfer(0, 1, 3'h5, 5'h0d, 1, 0, 8'h00, 0);
        xfer(1, 0, 3'h3, 5'h0d, 1, 0, 8'h00, 1);
        xfer(0, 0, 3'h3, 5'h0e, 0, 0, 8'h00, 0);
        mode(dra_pkg::BL_FIX8, 1);
        xfer(0, 0, 3'h3, 5'h0e, 0, 0, 8'h00, 0);
        mode(dra_pkg::BL_BC4, 0);
        xfer(0, 1, 3'h5, 5'h0b, 1, 0, 8'h00, 0);
        mode(dra_pkg::BL_FIX8, 0);
        xfer(1, 0, 3'h3, 5'h0d, 1, 0, 8'ha5, 0);
        xfer(0, 0, 3'h3, 5'h0d, 1, 0, 8'h00, 0);
        tdqs = 1;
        mr(dra_pkg::MR1_SEL, 15'h800);
        xfer(1, 0, 3'h3, 5'h0d, 1, 0, 8'hff, 0);
        xfer(0, 0, 3'h3, 5'h0d, 1, 1, 8'h00, 0);
        xfer(0, 0, 3'h3, 5'h0d, 1, 0, 8'h00, 0);
        cmd_to(1, dra_pkg::CMD_PRE, 3'h0, 15'h400);
        foreach (opn[1][i]) opn[1][i] = 0;
        xfer(0, 1, 3'h5, 5'h0d, 1, 0, 8'h00, 0);
        @(posedge mclk) cfg_x8 <= 1'b0;
        x8 = 0;
        repeat (10) @(posedge mclk);
        act(0, 3'h3);
        xfer(1, 0, 3'h3, 5'h10, 1, 0, 8'h00, 0);
        xfer(0, 0, 3'h3, 5'h10, 1, 0, 8'h00, 0);
        comparisons++;
        if (q.size() != 0 || busy !== 1'b0) bad("leftover beats", 0, q.size());
        finish_test();
    end
endmodule : tb_dual_rank_ddr3_data_access
`default_nettype wire

// *** verilog/dra_ddr3_dev.sv ***
// Dual-rank DDR3 device data path: command decode, banks, burst engine
`timescale 1ns/10ps
`default_nettype none
module dra_ddr3_dev #(
    parameter int ROW_W = 2,
    parameter int COL_W = 5
) (
    input  wire logic                       mclk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       cfg_x8_i,
    output logic                            busy_o,
    input  wire logic                       link_clk_i,
    input  wire dra_pkg::dra_cmd_bus_t      cmd_i,
    input  wire logic [7:0]                 dq_i,
    output logic [7:0]                      dq_o,
    output logic [7:0]                      dq_oe_o,
    input  wire logic                       dqs_i,
    input  wire logic                       dm_i,
    output logic                            dqs_o,
    output logic                            dqs_n_o,
    output logic                            dqs_oe_o,
    output logic                            tdqs_o,
    output logic                            tdqs_n_o,
    output logic                            tdqs_oe_o
);
    localparam int WORD_W = dra_pkg::BEATS * dra_pkg::LANE_W;
    localparam int BID_W  = 1 + dra_pkg::BA_W;
    localparam int IDX_W  = BID_W + ROW_W + COL_W - dra_pkg::BEAT_W;
    localparam int RD_DLY = 2 * dra_pkg::RL_CK + 1;
    localparam logic [4:0] RL_HALF = 5'(2 * dra_pkg::RL_CK - 1);
    localparam logic [4:0] WL_HALF = 5'(2 * dra_pkg::WL_CK - 1);

    // Beat order within a burst: sequential wraps, interleaved xors
    function automatic logic [2:0] beat_idx(input logic [2:0] start, input logic [2:0] n,
                                            input logic ilv);
        beat_idx = ilv ? (start ^ n) : 3'(start + n);
    endfunction : beat_idx

    // ---------------------------------------------------------------
    // Core clock domain and crossings
    // ---------------------------------------------------------------
    logic [1:0] rst_s_r, ce_s_r, x8_s_r, busy_s_r;
    logic       x8_r, lbusy_r, lrst, lce, x8;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            x8_r     <= 1'b0;
            busy_s_r <= 2'h0;
            busy_o   <= 1'b0;
        end else if (ce_i) begin
            x8_r     <= cfg_x8_i;
            busy_s_r <= {busy_s_r[0], lbusy_r};
            busy_o   <= busy_s_r[1];
        end
    end
    always_ff @(posedge link_clk_i) begin
        rst_s_r <= {rst_s_r[0], rst_i};
        ce_s_r  <= {ce_s_r[0], ce_i};
        x8_s_r  <= {x8_s_r[0], x8_r};
    end
    assign lrst = rst_s_r[1];
    assign lce  = ce_s_r[1];
    assign x8   = x8_s_r[1];

    // ---------------------------------------------------------------
    // Command decode (link clock is twice CK: phase 0 is the CK rise)
    // ---------------------------------------------------------------
    logic                       ph_r;
    logic [ROW_W-1:0]           row_r [dra_pkg::RANKS * dra_pkg::BANKS];
    logic [15:0]                open_r;
    logic [dra_pkg::ADDR_W-1:0] mr0_r, mr1_r;
    dra_pkg::dra_state_t  st_r;
    wire                  sel    = ~&cmd_i.cs_n;
    wire                  rank   = cmd_i.cs_n[0];
    wire                  go     = sel & lce & ~ph_r;
    wire dra_pkg::dra_cmd_t cmd  = dra_pkg::dra_cmd_t'(cmd_i.rcw);
    wire [BID_W-1:0]      bid    = {rank, cmd_i.ba};
    wire                  act_go = go & (cmd == dra_pkg::CMD_ACT);
    wire                  pre_go = go & (cmd == dra_pkg::CMD_PRE);
    wire                  mrs_go = go & (cmd == dra_pkg::CMD_MRS);
    wire                  acc_ok = go & (st_r == dra_pkg::ST_IDLE) & open_r[bid];
    wire                  rd_go  = acc_ok & (cmd == dra_pkg::CMD_RD);
    wire                  wr_go  = acc_ok & (cmd == dra_pkg::CMD_WR);
    wire                  ap     = cmd_i.addr[dra_pkg::AP_BIT];
    wire [1:0]            bl     = mr0_r[dra_pkg::MR_BL_LSB +: 2];
    wire                  bc4    = (bl == dra_pkg::BL_BC4) |
                                   ((bl == dra_pkg::BL_OTF) & ~cmd_i.addr[dra_pkg::BC_BIT]);
    wire                  tdqs_en = x8 & mr1_r[dra_pkg::MR_TDQS];
    wire [IDX_W-1:0]      idx    = {bid, row_r[bid], cmd_i.addr[COL_W-1:dra_pkg::BEAT_W]};

    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            ph_r   <= 1'b0;
            open_r <= 16'h0000;
            mr0_r  <= '0;
            mr1_r  <= '0;
        end else if (lce) begin
            ph_r <= ~ph_r;
            if (act_go) begin
                open_r[bid] <= 1'b1;
                row_r[bid]  <= cmd_i.addr[ROW_W-1:0];
            end else if (pre_go) begin
                if (ap)
                    open_r <= open_r & {8'(rank ? 8'hff : 8'h00), 8'(rank ? 8'h00 : 8'hff)} ^ open_r;
                else
                    open_r[bid] <= 1'b0;
            end else if ((rd_go | wr_go) & ap) begin
                open_r[bid] <= 1'b0;
            end else if (mrs_go & (cmd_i.ba == dra_pkg::MR0_SEL)) begin
                mr0_r <= cmd_i.addr;
            end else if (mrs_go & (cmd_i.ba == dra_pkg::MR1_SEL)) begin
                mr1_r <= cmd_i.addr;
            end
        end
    end

    // ---------------------------------------------------------------
    // Burst engine and core array
    // ---------------------------------------------------------------
    logic [WORD_W-1:0] mem [2**IDX_W];
    logic [WORD_W-1:0] word_r;
    logic [IDX_W-1:0]  idx_r;
    logic [4:0]        lat_r;
    logic [2:0]        beat_r, start_r;
    logic              len4_r, ilv_r;
    wire               live   = (lat_r == 5'h00);
    wire               last   = beat_r == (len4_r ? 3'(dra_pkg::BC_BEATS - 1) :
                                                    3'(dra_pkg::BEATS - 1));
    wire               rd_now = (st_r == dra_pkg::ST_RD) & live;
    wire               wr_now = (st_r == dra_pkg::ST_WR) & live;
    wire [2:0]         bi     = beat_idx(start_r, beat_r, ilv_r);
    wire [7:0]         lanes  = x8 ? dra_pkg::LANE_X8 : dra_pkg::LANE_X4;
    wire [7:0]         wmask  = (dm_i & ~tdqs_en) ? 8'h00 : lanes;
    wire [7:0]         old_b  = word_r[bi*dra_pkg::LANE_W +: dra_pkg::LANE_W];

    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            st_r    <= dra_pkg::ST_IDLE;
            lat_r   <= 5'h00;
            beat_r  <= 3'h0;
            lbusy_r <= 1'b0;
        end else if (lce) begin
            lbusy_r <= st_r != dra_pkg::ST_IDLE;
            case (st_r)
                dra_pkg::ST_IDLE: begin
                    beat_r <= 3'h0;
                    if (rd_go | wr_go) begin
                        st_r    <= rd_go ? dra_pkg::ST_RD : dra_pkg::ST_WR;
                        lat_r   <= rd_go ? RL_HALF : WL_HALF;
                        word_r  <= mem[idx];
                        idx_r   <= idx;
                        start_r <= cmd_i.addr[dra_pkg::BEAT_W-1:0];
                        len4_r  <= bc4;
                        ilv_r   <= mr0_r[dra_pkg::MR_BT_BIT];
                    end
                end
                dra_pkg::ST_RD, dra_pkg::ST_WR: begin
                    if (!live) begin
                        lat_r <= lat_r - 5'h01;
                    end else begin
                        beat_r <= beat_r + 3'h1;
                        if (wr_now)
                            word_r[bi*dra_pkg::LANE_W +: dra_pkg::LANE_W] <=
                                (dq_i & wmask) | (old_b & ~wmask);
                        if (last)
                            st_r <= rd_now ? dra_pkg::ST_IDLE : dra_pkg::ST_WB;
                    end
                end
                dra_pkg::ST_WB: begin
                    mem[idx_r] <= word_r;
                    st_r       <= dra_pkg::ST_IDLE;
                end
                default: st_r <= dra_pkg::ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Read drivers: strobe rises with even beats, falls with odd beats
    // ---------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            dq_o      <= 8'h00;
            dq_oe_o   <= 8'h00;
            dqs_o     <= 1'b0;
            dqs_n_o   <= 1'b1;
            dqs_oe_o  <= 1'b0;
            tdqs_o    <= 1'b0;
            tdqs_n_o  <= 1'b0;
            tdqs_oe_o <= 1'b0;
        end else if (lce) begin
            dq_o      <= rd_now ? (old_b & lanes) : 8'h00;
            dq_oe_o   <= rd_now ? lanes : 8'h00;
            dqs_o     <= rd_now & ~beat_r[0];
            dqs_n_o   <= ~(rd_now & ~beat_r[0]);
            dqs_oe_o  <= rd_now;
            tdqs_o    <= tdqs_en & rd_now & ~beat_r[0];
            tdqs_n_o  <= tdqs_en & ~(rd_now & ~beat_r[0]);
            tdqs_oe_o <= tdqs_en & rd_now;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge link_clk_i); endclocking
    default disable iff (lrst || !lce);

    sequence s_four_beats;
        dqs_oe_o [*4];
    endsequence

    a_read_latency: assert property (rd_go |-> ##RD_DLY dqs_oe_o)
        else $error("read data not driven after read latency");
    a_burst_full: assert property ($rose(dqs_oe_o) && !len4_r |-> s_four_beats ##0 1 ##1 s_four_beats ##1 !dqs_oe_o)
        else $error("full burst is not eight beats");
    a_burst_chop: assert property ($rose(dqs_oe_o) && len4_r |-> s_four_beats ##1 !dqs_oe_o)
        else $error("chopped burst is not four beats");
    a_strobe_edge: assert property (dqs_oe_o && $past(dqs_oe_o) |-> dqs_o != $past(dqs_o))
        else $error("strobe did not toggle with read beat");
    a_strobe_pair: assert property (dqs_n_o == !dqs_o)
        else $error("strobe pair not complementary");
    a_x4_upper: assert property (!x8 |-> dq_oe_o[7:4] == 4'h0 && !tdqs_oe_o)
        else $error("x4 drives width dependent balls");
    a_deselect_ignore: assert property (&cmd_i.cs_n && st_r == dra_pkg::ST_IDLE |=> st_r == dra_pkg::ST_IDLE)
        else $error("deselected command was taken");
    a_act_opens: assert property (act_go |=> open_r[$past(bid)])
        else $error("activate did not open the row");
    a_auto_pre: assert property ((rd_go || wr_go) && ap |=> !open_r[$past(bid)])
        else $error("auto precharge left the bank open");
endmodule : dra_ddr3_dev
`default_nettype wire

// *** verilog/dra_pkg.sv ***
// Shared constants and types for the dual-rank DDR3 data access block
package dra_pkg;
    localparam int RANKS     = 2;
    localparam int BANKS     = 8;
    localparam int BA_W      = 3;
    localparam int ADDR_W    = 15;
    localparam int LANE_W    = 8;
    localparam int BEATS     = 8;
    localparam int BEAT_W    = 3;
    localparam int BC_BEATS  = 4;
    localparam int AP_BIT    = 10;
    localparam int BC_BIT    = 12;
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_TDQS   = 11;
    localparam int RL_CK     = 5;
    localparam int WL_CK     = 5;
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF  = 2'h1;
    localparam logic [1:0] BL_BC4  = 2'h2;
    localparam logic [2:0] MR0_SEL = 3'h0;
    localparam logic [2:0] MR1_SEL = 3'h1;
    localparam logic [7:0] LANE_X8 = 8'hff;
    localparam logic [7:0] LANE_X4 = 8'h0f;

    typedef enum logic [2:0] {
        CMD_MRS = 3'h0,
        CMD_PRE = 3'h2,
        CMD_ACT = 3'h3,
        CMD_WR  = 3'h4,
        CMD_RD  = 3'h5
    } dra_cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RD   = 4'h2,
        ST_WR   = 4'h4,
        ST_WB   = 4'h8
    } dra_state_t;

    typedef struct packed {
        logic [1:0]        cs_n;
        logic [2:0]        rcw;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
    } dra_cmd_bus_t;
endpackage : dra_pkg
